// ### hdl/scer_cfg.svh
// Offsets, field positions, reset values and timing counts of the router.
`ifndef SCER_CFG_SVH
`define SCER_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define SCER_ADDR_CTRL 8'h00
`define SCER_ADDR_STATUS 8'h04
`define SCER_ADDR_IRQ_STAT 8'h08
`define SCER_ADDR_IRQ_MASK 8'h0c
`define SCER_ADDR_EXP0 8'h10
`define SCER_ADDR_EXP1 8'h14
`define SCER_ADDR_REF_FREQ 8'h18

// ----------------------------------------------------------------------
// Control register fields (bits 0-3 write one to act and read back zero; bits 4-6 are held and read back)
// ----------------------------------------------------------------------
`define SCER_CTRL_COMMIT 0
`define SCER_CTRL_INITIATE 1
`define SCER_CTRL_ABORT 2
`define SCER_CTRL_CLR_ERR 3
`define SCER_CTRL_EXT_SEL 4
`define SCER_CTRL_PAT_EN 5
`define SCER_CTRL_REF_EN 6

// ----------------------------------------------------------------------
// Status and interrupt bit positions
// ----------------------------------------------------------------------
`define SCER_ST_RUNNING 0
`define SCER_ST_CLK_ERR 1
`define SCER_ST_CLK_OK 2
`define SCER_ST_COMMITTED 3
`define SCER_ST_REF_LOW 4
`define SCER_IRQ_CLK_ERR 0
`define SCER_IRQ_START 1
`define SCER_IRQ_START_FAIL 2

// ----------------------------------------------------------------------
// Export resource fields: source [1:0], dest [5:2], divisor [21:8]
// ----------------------------------------------------------------------
`define SCER_EXP_SRC_LSB 0
`define SCER_EXP_DST_LSB 2
`define SCER_EXP_DIV_LSB 8
`define SCER_EXP_RESET 32'h0000_0000

// ----------------------------------------------------------------------
// Reference frequency setting in MHz
// ----------------------------------------------------------------------
`define SCER_REF_MIN_MHZ 5'd1
`define SCER_REF_MAX_MHZ 5'd20
`define SCER_REF_SPEC_MHZ 5'd5
`define SCER_REF_RESET 5'd10

// ----------------------------------------------------------------------
// Clock supervision timing
// ----------------------------------------------------------------------
`define SCER_CLK_MHZ 25
`define SCER_WATCH_NS 400
`define SCER_WATCH_CYC ((`SCER_WATCH_NS * `SCER_CLK_MHZ) / 1000)
`define SCER_PERIOD_TOL 4'd1

`endif

// ### hdl/scer_pkg.sv
// Types shared by the sample clock export router.
package scer_pkg;

    typedef enum logic [1:0] {
        SCER_SRC_OFF,
        SCER_SRC_SAMPLE,
        SCER_SRC_TIMEBASE,
        SCER_SRC_REFERENCE
    } scer_src_e;

    // Destinations 0..6: card trigger lines, 7: star, 8..9: function
    // pins, 10: digital port clock, 11: card line seven.
    typedef logic [3:0] scer_dst_t;

    typedef struct packed {
        scer_src_e src;
        scer_dst_t dst;
        logic [13:0] div;
    } scer_exp_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scer_bus_s;

    typedef struct packed {
        logic [6:0] trig;
        logic star;
        logic [1:0] pin;
        logic portClk;
        logic lineSeven;
    } scer_pins_s;

endpackage : scer_pkg

// ### hdl/sample_clock_export_router.sv
// Sample clock supervision, generation control and clock export routing.
//
// Local design decisions: the address map and the plain strobed port.
`include "scer_cfg.svh"

module sample_clock_export_router (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire scer_pkg::scer_bus_s bus,
    output scer_pkg::scer_bus_s unusedBus,
    output logic [31:0] rdata,
    // Clock sources
    input wire logic extClk,
    input wire logic sampleTick,
    input wire logic timebaseTick,
    input wire logic refTick,
    input wire logic onboardRefTick,
    input wire logic onboardRefPresent,
    // Export pins
    output scer_pkg::scer_pins_s pinOut,
    output scer_pkg::scer_pins_s pinOe,
    // Generation state and interrupt
    output logic running,
    output logic irq
);
    import scer_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic extSel;
    logic patEn;
    logic refEn;
    logic [4:0] refMhz;
    scer_exp_s exp [2];
    logic clkErr;
    logic committed;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic [2:0] irqEvt;

    wire logic wrCtrl = bus.wr && bus.addr == `SCER_ADDR_CTRL;
    wire logic doCommit = wrCtrl && bus.wdata[`SCER_CTRL_COMMIT];
    wire logic doInit = wrCtrl && bus.wdata[`SCER_CTRL_INITIATE];
    wire logic doAbort = wrCtrl && bus.wdata[`SCER_CTRL_ABORT];
    wire logic doClear = wrCtrl && bus.wdata[`SCER_CTRL_CLR_ERR];

    assign unusedBus = '0;

    // ------------------------------------------------------------------
    // External clock synchroniser: three stages, rising edge when 2 is high and 3 is low
    // ------------------------------------------------------------------
    logic [2:0] extSync;
    always_ff @(posedge clk)
    begin
        if (!rstn)
            extSync <= 3'h0;
        else
            extSync <= {extSync[1:0], extClk};
    end
    wire logic extRise = extSync[1] && !extSync[2];

    // ------------------------------------------------------------------
    // Clock monitor: measures rise spacing, flags loss or period change.
    // Only periods within the window are measurable, which limits the
    // external rate the monitor can judge to above about 2.5 MHz.
    // ------------------------------------------------------------------
    localparam int WATCH = (`SCER_WATCH_CYC < 1) ? 1 : `SCER_WATCH_CYC;
    logic [3:0] gapCnt;
    logic [3:0] lastGap;
    logic haveGap;
    logic clkOk;
    logic clkBad;

    always_ff @(posedge clk)
    begin
        if (!rstn)
            gapCnt <= 4'h0;
        else if (extRise)
            gapCnt <= 4'h1;
        else if (gapCnt != 4'hf)
            gapCnt <= gapCnt + 4'h1;
    end

    always_comb
    begin
        clkBad = 1'b0;
        if (gapCnt >= 4'(WATCH))
            clkBad = 1'b1;
        else if (extRise && haveGap)
            clkBad = (gapCnt > lastGap + `SCER_PERIOD_TOL)
                || (gapCnt + `SCER_PERIOD_TOL < lastGap);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn || gapCnt >= 4'(WATCH))
        begin
            lastGap <= 4'h0;
            haveGap <= 1'b0;
            clkOk <= 1'b0;
        end
        else if (extRise)
        begin
            lastGap <= gapCnt;
            haveGap <= 1'b1;
            clkOk <= haveGap && !clkBad;
        end
    end

    // ------------------------------------------------------------------
    // Commit, initiate and abort sequencing
    // ------------------------------------------------------------------
    wire logic needExt = extSel;
    wire logic extFault = needExt && (clkBad || !clkOk);
    wire logic startOk = doInit && committed && !clkErr && !extFault;

    // A commit with the external clock selected but not running is refused as an error.
    always_ff @(posedge clk)
    begin
        if (!rstn)
            committed <= 1'b0;
        else if (doCommit)
            committed <= !extFault;
        else if (bus.wr && bus.addr != `SCER_ADDR_CTRL
                && bus.addr != `SCER_ADDR_IRQ_MASK && !running)
            committed <= 1'b0;
        else if (doInit && !clkErr && !extFault)
            committed <= 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            clkErr <= 1'b0;
        else if ((running && extFault)
                || ((doCommit || doInit) && extFault))
            clkErr <= 1'b1;
        else if (doClear)
            clkErr <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            running <= 1'b0;
        else if (doAbort || (running && extFault))
            running <= 1'b0;
        else if (startOk || (doInit && !committed && !clkErr
                && !extFault))
            running <= 1'b1;
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            extSel <= 1'b0;
            patEn <= 1'b0;
            refEn <= 1'b0;
        end
        else if (wrCtrl)
        begin
            if (!running)
                extSel <= bus.wdata[`SCER_CTRL_EXT_SEL];
            patEn <= bus.wdata[`SCER_CTRL_PAT_EN];
            refEn <= bus.wdata[`SCER_CTRL_REF_EN];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            refMhz <= `SCER_REF_RESET;
        else if (bus.wr && bus.addr == `SCER_ADDR_REF_FREQ
                && bus.wdata[4:0] >= `SCER_REF_MIN_MHZ
                && bus.wdata[4:0] <= `SCER_REF_MAX_MHZ
                && bus.wdata[31:5] == 27'h0)
            refMhz <= bus.wdata[4:0];
    end

    // Pairings that the hardware cannot make are refused at write time.
    function automatic logic pairLegal(input logic [31:0] w);
        logic [1:0] s;
        logic [3:0] d;
        s = w[`SCER_EXP_DST_LSB-1:`SCER_EXP_SRC_LSB];
        d = w[`SCER_EXP_DST_LSB+3:`SCER_EXP_DST_LSB];
        pairLegal = 1'b1;
        if (s == 2'(SCER_SRC_OFF))
            pairLegal = 1'b1;
        else if (d == 4'hb)
            pairLegal = 1'b0;
        else if (d == 4'ha)
            pairLegal = s != 2'(SCER_SRC_REFERENCE);
        else if (d > 4'hb)
            pairLegal = 1'b0;
        else if (s != 2'(SCER_SRC_OFF)
                && w[`SCER_EXP_DIV_LSB+13:`SCER_EXP_DIV_LSB] == 14'h1)
            pairLegal = 1'b0;
    endfunction : pairLegal

    // Writing source off with line seven selects the onboard reference.
    function automatic logic isLineSeven(input scer_exp_s e);
        isLineSeven = e.src == SCER_SRC_OFF && e.dst == 4'hb;
    endfunction : isLineSeven

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gExp
            localparam logic [7:0] ADDR = g == 0 ? `SCER_ADDR_EXP0
                : `SCER_ADDR_EXP1;
            always_ff @(posedge clk)
            begin
                if (!rstn)
                    exp[g] <= scer_exp_s'(`SCER_EXP_RESET);
                else if (bus.wr && bus.addr == ADDR
                        && pairLegal(bus.wdata))
                    exp[g] <= scer_exp_s'({
                        bus.wdata[`SCER_EXP_DST_LSB-1:0],
                        bus.wdata[`SCER_EXP_DST_LSB+3:`SCER_EXP_DST_LSB],
                        bus.wdata[`SCER_EXP_DIV_LSB+13:`SCER_EXP_DIV_LSB]
                    });
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Export dividers: a divisor of 0 or 1 passes the tick undivided
    // ------------------------------------------------------------------
    logic [1:0] srcTick;
    logic [1:0] divOut;
    logic [1:0] directOut;
    logic [13:0] divCnt [2];

    generate
        for (g = 0; g < 2; g++)
        begin : gDiv
            always_comb
            begin
                case (exp[g].src)
                    SCER_SRC_SAMPLE: srcTick[g] = sampleTick;
                    SCER_SRC_TIMEBASE: srcTick[g] = timebaseTick;
                    SCER_SRC_REFERENCE:
                        srcTick[g] = refEn && refTick;
                    default: srcTick[g] = 1'b0;
                endcase
            end
            always_ff @(posedge clk)
            begin
                if (!rstn || exp[g].src == SCER_SRC_OFF)
                begin
                    divCnt[g] <= 14'h0;
                    divOut[g] <= 1'b0;
                    directOut[g] <= 1'b0;
                end
                else
                begin
                    directOut[g] <= srcTick[g];
                    if (exp[g].div < 14'h2)
                        divOut[g] <= srcTick[g];
                    else if (srcTick[g])
                    begin
                        if (divCnt[g] >= exp[g].div - 14'h1)
                        begin
                            divCnt[g] <= 14'h0;
                            divOut[g] <= 1'b1;
                        end
                        else
                        begin
                            divCnt[g] <= divCnt[g] + 14'h1;
                            divOut[g] <= 1'b0;
                        end
                    end
                    else
                        divOut[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Destination routing; resource 0 wins if both pick one destination
    // ------------------------------------------------------------------
    scer_pins_s next_pinOut;
    scer_pins_s next_pinOe;

    always_comb
    begin
        next_pinOut = '0;
        next_pinOe = '0;
        for (int r = 1; r >= 0; r--)
        begin
            if (exp[r].src != SCER_SRC_OFF
                    && (exp[r].src != SCER_SRC_REFERENCE || refEn))
            begin
                if (exp[r].dst < 4'h7)
                begin
                    next_pinOut.trig[exp[r].dst[2:0]] = divOut[r];
                    next_pinOe.trig[exp[r].dst[2:0]] = 1'b1;
                end
                else if (exp[r].dst == 4'h7)
                begin
                    next_pinOut.star = divOut[r];
                    next_pinOe.star = 1'b1;
                end
                else if (exp[r].dst < 4'ha)
                begin
                    next_pinOut.pin[exp[r].dst[0]] = divOut[r];
                    next_pinOe.pin[exp[r].dst[0]] = 1'b1;
                end
                else if (exp[r].dst == 4'ha && patEn)
                begin
                    next_pinOut.portClk = directOut[r];
                    next_pinOe.portClk = 1'b1;
                end
            end
            else if (isLineSeven(exp[r]) && onboardRefPresent)
            begin
                next_pinOut.lineSeven = onboardRefTick;
                next_pinOe.lineSeven = 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            pinOut <= '0;
            pinOe <= '0;
        end
        else
        begin
            pinOut <= next_pinOut;
            pinOe <= next_pinOe;
        end
    end

    // ------------------------------------------------------------------
    // Interrupts: sticky, cleared by reading, set wins over the clear
    // ------------------------------------------------------------------
    assign irqEvt = {doInit && !startOk && !(doInit && !committed
            && !clkErr && !extFault), running == 1'b0
            && (startOk || (doInit && !committed && !clkErr
            && !extFault)), !clkErr && ((running && extFault)
            || ((doCommit || doInit) && extFault))};

    always_ff @(posedge clk)
    begin
        if (!rstn)
            irqStat <= 3'h0;
        else if (bus.rd && bus.addr == `SCER_ADDR_IRQ_STAT)
            irqStat <= irqEvt;
        else
            irqStat <= irqStat | irqEvt;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            irqMask <= 3'h0;
        else if (bus.wr && bus.addr == `SCER_ADDR_IRQ_MASK)
            irqMask <= bus.wdata[2:0];
    end

    assign irq = |(irqStat & irqMask);

    // ------------------------------------------------------------------
    // Read data, one cycle after the strobe; unmapped reads return zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn || !bus.rd)
            rdata <= 32'h0;
        else
        begin
            case (bus.addr)
                `SCER_ADDR_CTRL:
                    rdata <= 32'({refEn, patEn, extSel, 4'h0});
                `SCER_ADDR_STATUS:
                    rdata <= 32'({refMhz < `SCER_REF_SPEC_MHZ, committed,
                        clkOk, clkErr, running});
                `SCER_ADDR_IRQ_STAT: rdata <= 32'(irqStat);
                `SCER_ADDR_IRQ_MASK: rdata <= 32'(irqMask);
                `SCER_ADDR_EXP0:
                    rdata <= 32'({exp[0].div, 2'h0, exp[0].dst,
                        exp[0].src});
                `SCER_ADDR_EXP1:
                    rdata <= 32'({exp[1].div, 2'h0, exp[1].dst,
                        exp[1].src});
                `SCER_ADDR_REF_FREQ: rdata <= 32'(refMhz);
                default: rdata <= 32'h0;
            endcase
        end
    end

endmodule : sample_clock_export_router

// ### tb/scer_router_checker.sv
// Port-level assertions for the sample clock export router.
`include "scer_cfg.svh"
module scer_router_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Watched ports
    input wire scer_pkg::scer_bus_s bus,
    input wire logic [31:0] rdata,
    input wire logic extClk,
    input wire logic onboardRefPresent,
    input wire scer_pkg::scer_pins_s pinOut,
    input wire scer_pkg::scer_pins_s pinOe,
    input wire logic running
);
    import scer_pkg::*;
    logic extQ;
    logic [5:0] quiet;
    logic ctrlWr;
    assign ctrlWr = bus.wr && bus.addr == `SCER_ADDR_CTRL;
    always_ff @(posedge clk)
    begin
        extQ <= extClk;
    end
    // Counts clk cycles with no edge on the raw pin; saturates.
    always_ff @(posedge clk)
    begin
        if (!rstn || extQ != extClk)
            quiet <= 6'h00;
        else if (quiet != 6'h3f)
            quiet <= quiet + 6'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_start_cause: assert property ($rose(running) |->
        $past(ctrlWr && bus.wdata[`SCER_CTRL_INITIATE]))
        else $error("generation started without initiate");
    a_abort_stops: assert property (ctrlWr &&
        bus.wdata[`SCER_CTRL_ABORT] |=> !running)
        else $error("generation still running after abort");
    a_dead_no_start: assert property (ctrlWr &&
        bus.wdata[`SCER_CTRL_INITIATE] && !running && quiet > 6'd20
        |=> !running)
        else $error("generation started with no external clock");
    a_line_seven_src: assert property (pinOe.lineSeven |->
        onboardRefPresent)
        else $error("line seven driven without onboard reference");
    a_oe_gates_out: assert property (
        (12'(pinOut) & ~12'(pinOe)) == 12'h000)
        else $error("pin pulses while not enabled");
    a_ctrl_read: assert property ($past(bus.rd &&
        bus.addr == `SCER_ADDR_CTRL) |->
        rdata[31:7] == 25'h0 && rdata[3:0] == 4'h0)
        else $error("control read shows pulse bits");
    a_status_width: assert property ($past(bus.rd &&
        bus.addr == `SCER_ADDR_STATUS) |-> rdata[31:5] == 27'h0)
        else $error("status read shows unused bits");
    a_ref_range: assert property ($past(bus.rd &&
        bus.addr == `SCER_ADDR_REF_FREQ) |->
        rdata >= 32'd1 && rdata <= 32'd20)
        else $error("reference setting out of range");
    c_start: cover property ($rose(running));
    c_refused: cover property (ctrlWr && bus.wdata[1] && quiet > 6'd20);
    c_line_seven: cover property ($rose(pinOut.lineSeven));
endmodule : scer_router_checker

bind sample_clock_export_router scer_router_checker u_chk (.clk(clk),
    .rstn(rstn), .bus(bus), .rdata(rdata), .extClk(extClk),
    .onboardRefPresent(onboardRefPresent), .pinOut(pinOut),
    .pinOe(pinOe), .running(running));

// ### tb/scer_ext_clock.sv
// Behavioural external sample clock source.
module scer_ext_clock (
    // Clock
    input wire logic clk,
    // Control
    input wire logic run,
    // Clock pin
    output logic extClk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] phase = 2'h0;
    initial extClk = 1'b0;
    // Steady rate while on; a removed source leaves the pin still.
    always @(posedge clk)
    begin
        if (run)
            phase <= phase + 2'h1;
        if (run && phase[0])
            extClk <= ~extClk;
    end
endmodule : scer_ext_clock

// ### tb/test_sample_clock_export_router.sv
// Self-checking bench for the sample clock export router.
`include "scer_cfg.svh"
module test_sample_clock_export_router;
    timeunit 1ns;
    timeprecision 1ps;
    import scer_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    scer_bus_s bus = '0;
    logic [31:0] rdata;
    logic extRun = 1'b0;
    logic extClk;
    logic [3:0] tick = 4'h0;
    scer_pins_s pinOut;
    scer_pins_s pinOe;
    logic running;
    logic irq;
    logic [11:0] outVec;
    logic [11:0] oeVec;
    logic [31:0] d;
    int fails = 0;
    int num_checks = 0;
    int cnt = 0;
    int sel = 0;
    assign outVec = pinOut;
    assign oeVec = pinOe;
    always #20 clk = ~clk;
    always @(posedge clk)
        if (outVec[sel] === 1'b1)
            cnt <= cnt + 1;

    sample_clock_export_router dut (.clk(clk), .rstn(rstn), .bus(bus),
        .unusedBus(), .rdata(rdata), .extClk(extClk),
        .sampleTick(tick[0]), .timebaseTick(tick[1]), .refTick(tick[2]),
        .onboardRefTick(tick[3]), .onboardRefPresent(1'b1),
        .pinOut(pinOut), .pinOe(pinOe), .running(running), .irq(irq));
    scer_ext_clock u_src (.clk(clk), .run(extRun), .extClk(extClk));

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize
    task automatic check32(input string w, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            fails++;
            $display("ERROR %s expected %h seen %h", w, e, g);
        end
    endtask : check32
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        // Let the outputs launched at this edge settle before callers look.
        #1;
    endtask : wr
    task automatic expRd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e, input string w);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        check32(w, e, rdata & m);
    endtask : expRd
    // Writes one export word, sends n source ticks, counts pin pulses.
    task automatic route(input logic [7:0] a, input logic [1:0] s,
        input logic [3:0] t, input logic [13:0] v, input int i,
        input int n, input int b, input int e);
        wr(a, {10'h0, v, 2'h0, t, s});
        repeat (2) @(posedge clk);
        sel = b;
        #1 cnt = 0;
        repeat (n)
        begin
            @(posedge clk);
            tick[i] <= 1'b1;
            @(posedge clk);
            tick[i] <= 1'b0;
        end
        repeat (4) @(posedge clk);
        check32($sformatf("pulses on pin %0d", b), e, cnt);
        check32($sformatf("enable of pin %0d", b), {31'h0, e != 0},
            {31'h0, oeVec[b]});
    endtask : route

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        expRd(`SCER_ADDR_STATUS, 32'h1f, 32'h0, "status");
        expRd(`SCER_ADDR_REF_FREQ, 32'hff, 32'd10, "ref");
        expRd(`SCER_ADDR_EXP0, 32'hffffffff, 32'h0, "exp0");
        expRd(`SCER_ADDR_EXP1, 32'hffffffff, 32'h0, "exp1");
    endtask : t_reset
    task automatic t_ref_freq();
        logic [31:0] wv [6] = '{32'd0, 32'd21, 32'd1, 32'd20, 32'd5, 32'd4};
        logic [31:0] ev [6] = '{32'd10, 32'd10, 32'd1, 32'd20, 32'd5, 32'd4};
        for (int k = 0; k < 6; k++)
        begin
            wr(`SCER_ADDR_REF_FREQ, wv[k]);
            expRd(`SCER_ADDR_REF_FREQ, 32'hff, ev[k], "ref");
            expRd(`SCER_ADDR_STATUS, 32'h10, {27'h0, ev[k] < 32'd5, 4'h0},
                "ref low");
        end
        wr(`SCER_ADDR_REF_FREQ, 32'd10);
    endtask : t_ref_freq
    task automatic t_start();
        extRun <= 1'b1;
        repeat (20) @(posedge clk);
        expRd(`SCER_ADDR_STATUS, 32'h4, 32'h4, "clock ok");
        wr(`SCER_ADDR_CTRL, 32'h11);
        expRd(`SCER_ADDR_STATUS, 32'h8, 32'h8, "committed");
        wr(`SCER_ADDR_IRQ_MASK, 32'h7);
        wr(`SCER_ADDR_CTRL, 32'h12);
        check32("running", 32'h1, {31'h0, running});
        check32("irq", 32'h1, {31'h0, irq});
        expRd(`SCER_ADDR_IRQ_STAT, 32'h7, 32'h2, "irq stat");
        check32("irq", 32'h0, {31'h0, irq});
    endtask : t_start
    task automatic t_exports();
        for (int n = 0; n < 7; n++)
            route(`SCER_ADDR_EXP0, 2'd1, 4'(n), 14'd0, 0, 4, 5 + n, 4);
        route(`SCER_ADDR_EXP0, 2'd1, 4'd7, 14'd0, 0, 4, 4, 4);
        route(`SCER_ADDR_EXP0, 2'd1, 4'd8, 14'd3, 0, 12, 2, 4);
        route(`SCER_ADDR_EXP0, 2'd1, 4'd9, 14'd3, 0, 12, 3, 4);
        wr(`SCER_ADDR_CTRL, 32'h30);
        route(`SCER_ADDR_EXP0, 2'd1, 4'd10, 14'd5, 0, 5, 1, 5);
        route(`SCER_ADDR_EXP1, 2'd2, 4'd3, 14'd2, 1, 8, 8, 4);
        route(`SCER_ADDR_EXP1, 2'd3, 4'd9, 14'd0, 2, 4, 3, 0);
        wr(`SCER_ADDR_CTRL, 32'h70);
        route(`SCER_ADDR_EXP1, 2'd3, 4'd9, 14'd0, 2, 4, 3, 4);
        wr(`SCER_ADDR_EXP1, 32'h2b);
        expRd(`SCER_ADDR_EXP1, 32'h3f, 32'h27, "exp1");
        wr(`SCER_ADDR_EXP0, 32'h101);
        wr(`SCER_ADDR_EXP0, 32'h31);
        expRd(`SCER_ADDR_EXP0, 32'h3fffff, 32'h529, "exp0");
        route(`SCER_ADDR_EXP1, 2'd0, 4'd11, 14'd0, 3, 4, 0, 4);
        wr(`SCER_ADDR_EXP1, 32'h2d);
        expRd(`SCER_ADDR_EXP1, 32'h3f, 32'h2c, "exp1");
    endtask : t_exports
    task automatic t_clock_loss();
        wr(`SCER_ADDR_CTRL, 32'h74);
        check32("running", 32'h0, {31'h0, running});
        wr(`SCER_ADDR_IRQ_MASK, 32'h0);
        extRun <= 1'b0;
        repeat (30) @(posedge clk);
        wr(`SCER_ADDR_CTRL, 32'h72);
        extRun <= 1'b1;
        repeat (30) @(posedge clk);
        wr(`SCER_ADDR_CTRL, 32'h72);
        check32("running", 32'h0, {31'h0, running});
        expRd(`SCER_ADDR_STATUS, 32'h2, 32'h2, "clock error");
        check32("irq", 32'h0, {31'h0, irq});
        wr(`SCER_ADDR_IRQ_MASK, 32'h5);
        check32("irq", 32'h1, {31'h0, irq});
        expRd(`SCER_ADDR_IRQ_STAT, 32'h7, 32'h5, "irq stat");
        check32("irq", 32'h0, {31'h0, irq});
        wr(`SCER_ADDR_CTRL, 32'h78);
        expRd(`SCER_ADDR_STATUS, 32'h2, 32'h0, "clock error");
        wr(`SCER_ADDR_CTRL, 32'h72);
        check32("running", 32'h1, {31'h0, running});
    endtask : t_clock_loss

    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_ref_freq();
        t_start();
        t_exports();
        t_clock_loss();
        summarize();
    end
endmodule : test_sample_clock_export_router
